// ==== src/oovfr_core.sv ====
/*
  Output overvoltage fault response core. Holds the action byte, decodes
  it, times fault persistence in 10 us ticks, drives the low-side clamp,
  output disable, retry request, status flags and alert line.
  Assumes the comparator and enable inputs are asynchronous pins, while
  the register strobes, command pulses and retry interval come from
  logic on the same clock.
*/
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Fault sets summary, word and vout flags
// RL2: Fault asserts alert unless masked
// RL3: Code 00 clamps low side while overvoltage
// RL4: Code 80 disables output, never retries
// RL5: Code B8 disables, retries until stopped
// RL6: Code 4n latches off after n ticks
// RL7: Code 78+n shuts down, retries continuously
// RL8: Unrecognised write raises fault, keeps setting
// RL9: Byte splits into response, retry, delay
// RL10: Response 01 waits delay then acts
// RL11: Response 10 disables output immediately
// RL12: Retry 000 keeps output off until cleared
// RL13: Delay field counts 10 us steps
// RL14: Flags clear by command, toggle, power
// RL15: Retry interval from separate setting
// RL16: Interval from detection, waits output decay; code counts from shutdown
// RL17: Prescaled tick timer restarts on deassertion; code restarts only the tick count, the prescaler runs free
module oovfr_core
  import oovfr_pkg::*;
#(
  parameter int unsigned RETRY_W = 24
) (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic OV_COMPARE_I,
  input wire logic CHANNEL_ENABLE_I,
  input wire logic OUTPUT_DECAYED_I,
  input wire logic OTHER_FAULT_STOP_I,
  input wire logic ACTION_WRITE_I,
  input wire logic [7:0] ACTION_WDATA_I,
  input wire logic CLEAR_FAULTS_I,
  input wire logic RESET_CMD_I,
  input wire logic ALERT_MASK_I,
  input wire logic [RETRY_W-1:0] RETRY_INTERVAL_SETTING_I,
  output logic [7:0] ACTION_RDATA_O,
  output logic COMM_FAULT_O,
  output logic OVERVOLTAGE_LOW_SIDE_CLAMP_O,
  output logic HIGH_SIDE_OFF_O,
  output logic OUTPUT_DISABLE_O,
  output logic RETRY_START_O,
  output logic SUMMARY_OV_FLAG_O,
  output logic WORD_VOUT_FLAG_O,
  output logic OUTPUT_OVERVOLTAGE_FLAG_O,
  output logic ALERT_N_O
);
  import oovfr_pkg::*;

  // Check a written byte against the recognised set
  function automatic logic act_valid(input logic [7:0] v);
    logic ok;
    ok = (v == ACT_PULLDOWN) || (v == ACT_LATCH) || (v == ACT_RETRY);
    ok = ok || (v[7:3] == 5'h08) || (v[7:3] == 5'h0F);
    ok = ok && (v[RESP_HI:RESP_LO] != RESP_BAD);
    return ok;
  endfunction

  logic ov_meta_r; // First synchroniser stage, comparator
  logic ov_r; // Synchronised overvoltage
  logic en_meta_r; // First synchroniser stage, enable
  logic en_r; // Synchronised enable
  logic en_d_r; // Enable one cycle late, for edges
  logic [7:0] act_r; // Stored action byte
  logic [1:0] resp; // Response field
  logic [2:0] retry; // Retry field
  logic [2:0] delay; // Delay field
  // Prescaler width; it must hold a whole tick's count at this clock
  localparam int unsigned PRE_W = $clog2(TICK_CYC);
  logic [PRE_W-1:0] pre_r; // Tick prescaler
  logic tick; // One 10 us tick
  logic [2:0] pers_r; // Persistence ticks counted
  logic [RETRY_W-1:0] rint_r; // Retry interval ticks counted
  logic fault_ev; // Fault reaches its response
  logic on_cycle; // Off-then-on of the enable
  logic clr_flags; // Any flag clearing event
  oovfr_state_t st_r; // Response state
  oovfr_state_t st_nxt; // Next response state

  // Field decode of the stored byte
  assign resp = act_r[RESP_HI:RESP_LO]; // RL9
  assign retry = act_r[RETRY_HI:RETRY_LO]; // RL9
  assign delay = act_r[DELAY_HI:DELAY_LO]; // RL9
  assign tick = (pre_r == PRE_W'(TICK_CYC - 1));
  assign on_cycle = en_r && !en_d_r;
  assign clr_flags = CLEAR_FAULTS_I || on_cycle || RESET_CMD_I; // RL14
  // Persistence met: response 10 acts at once, 01 after delay ticks
  assign fault_ev = ov_r && (resp == RESP_IMMEDIATE || (pers_r == delay && resp == RESP_DELAYED)); // RL10 RL11

  // Two-flop synchronisers for the pins
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ov_meta_r <= 1'b0;
      ov_r <= 1'b0;
      en_meta_r <= 1'b0;
      en_r <= 1'b0;
      en_d_r <= 1'b0;
    end else begin
      ov_meta_r <= OV_COMPARE_I;
      ov_r <= ov_meta_r;
      en_meta_r <= CHANNEL_ENABLE_I;
      en_r <= en_meta_r;
      en_d_r <= en_r;
    end
  end

  // Action byte store; bad values are dropped and flagged
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      act_r <= ACT_RESET;
    end else if (ACTION_WRITE_I && act_valid(ACTION_WDATA_I)) begin
      act_r <= ACTION_WDATA_I;
    end
  end

  // Communication fault, sticky until clear faults; set wins
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      COMM_FAULT_O <= 1'b0;
    end else if (ACTION_WRITE_I && !act_valid(ACTION_WDATA_I)) begin
      COMM_FAULT_O <= 1'b1; // RL8
    end else if (CLEAR_FAULTS_I) begin
      COMM_FAULT_O <= 1'b0;
    end
  end

  // Free-running 10 us prescaler
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pre_r <= '0;
    end else if (tick) begin
      pre_r <= '0; // RL17
    end else begin
      pre_r <= pre_r + PRE_W'(1);
    end
  end

  // Persistence counter, restarts when overvoltage drops
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pers_r <= 3'h0;
    end else if (!ov_r || st_r != OOVFR_PERSIST) begin
      pers_r <= 3'h0; // RL17
    end else if (tick && pers_r != delay) begin
      pers_r <= pers_r + 3'h1; // RL13
    end
  end

  // Retry interval counter, runs from shutdown while in the off wait state
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rint_r <= '0;
    end else if (st_r != OOVFR_OFF_WAIT) begin
      rint_r <= '0; // RL16
    end else if (tick && rint_r != RETRY_INTERVAL_SETTING_I) begin
      rint_r <= rint_r + 1'b1; // RL15
    end
  end

  // Response state decision
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      OOVFR_IDLE: begin
        if (ov_r && resp != RESP_IGNORE && en_r) begin
          st_nxt = (resp == RESP_IMMEDIATE) ? OOVFR_OFF_WAIT : OOVFR_PERSIST; // RL11
        end
      end
      OOVFR_PERSIST: begin
        if (!ov_r) begin
          st_nxt = OOVFR_IDLE; // RL17
        end else if (fault_ev) begin
          st_nxt = OOVFR_OFF_WAIT; // RL10
        end
      end
      OOVFR_OFF_WAIT: begin
        if (retry == RETRY_NONE) begin
          st_nxt = OOVFR_OFF_LATCHED; // RL4 RL6 RL12
        end else if (rint_r == RETRY_INTERVAL_SETTING_I && OUTPUT_DECAYED_I) begin
          st_nxt = OOVFR_RESTART; // RL5 RL7 RL16
        end
      end
      OOVFR_RESTART: begin
        st_nxt = OOVFR_IDLE; // RL5 RL7
      end
      OOVFR_OFF_LATCHED: begin
        st_nxt = OOVFR_OFF_LATCHED; // RL6 RL12
      end
      default: begin
        st_nxt = OOVFR_IDLE;
      end
    endcase
    // Channel off, reset command or another fault stops retries
    if (!en_r || RESET_CMD_I || (OTHER_FAULT_STOP_I && st_r != OOVFR_OFF_LATCHED)) begin
      st_nxt = OTHER_FAULT_STOP_I && en_r && !RESET_CMD_I ? OOVFR_OFF_LATCHED : OOVFR_IDLE; // RL5
    end
  end

  // Response state register
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_r <= OOVFR_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Gate drive and output control
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      OVERVOLTAGE_LOW_SIDE_CLAMP_O <= 1'b0;
      HIGH_SIDE_OFF_O <= 1'b0;
      OUTPUT_DISABLE_O <= 1'b0;
      RETRY_START_O <= 1'b0;
    end else begin
      // Clamp whenever overvoltage is present: pull-down mode and all others
      OVERVOLTAGE_LOW_SIDE_CLAMP_O <= ov_r; // RL3
      HIGH_SIDE_OFF_O <= ov_r; // RL3
      OUTPUT_DISABLE_O <= (st_nxt == OOVFR_OFF_WAIT) || (st_nxt == OOVFR_OFF_LATCHED); // RL4 RL11
      RETRY_START_O <= (st_nxt == OOVFR_RESTART); // RL5 RL7
    end
  end

  // Sticky status flags; a new fault beats a clear in the same cycle
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SUMMARY_OV_FLAG_O <= 1'b0;
      WORD_VOUT_FLAG_O <= 1'b0;
      OUTPUT_OVERVOLTAGE_FLAG_O <= 1'b0;
    end else if (ov_r) begin
      SUMMARY_OV_FLAG_O <= 1'b1; // RL1
      WORD_VOUT_FLAG_O <= 1'b1; // RL1
      OUTPUT_OVERVOLTAGE_FLAG_O <= 1'b1; // RL1
    end else if (clr_flags) begin
      SUMMARY_OV_FLAG_O <= 1'b0; // RL14
      WORD_VOUT_FLAG_O <= 1'b0; // RL14
      OUTPUT_OVERVOLTAGE_FLAG_O <= 1'b0; // RL14
    end
  end

  // Alert and readback
  always_comb begin
    ALERT_N_O = !(OUTPUT_OVERVOLTAGE_FLAG_O && !ALERT_MASK_I); // RL2
    ACTION_RDATA_O = act_r;
  end
endmodule // oovfr_core

// ==== src/oovfr_pkg.sv ====
/*
  Package for the output overvoltage fault response block: action byte
  field layout, recognised codes, reset values and timing constants.
  Assumes a 20 MHz system clock.
*/
package oovfr_pkg;
  // System clock rate in Hz
  localparam int unsigned CLK_HZ = 20000000;
  // Persistence tick period in microseconds
  localparam int unsigned TICK_US = 10;
  // Cycles per 10 us tick (clock rounded down to whole MHz, no lower limit)
  localparam int unsigned TICK_CYC = (CLK_HZ / 1000000) * TICK_US;
  // Action byte width
  localparam int unsigned ACT_W = 8;
  // Field positions of the action byte
  localparam int unsigned RESP_HI = 7;
  localparam int unsigned RESP_LO = 6;
  localparam int unsigned RETRY_HI = 5;
  localparam int unsigned RETRY_LO = 3;
  localparam int unsigned DELAY_HI = 2;
  localparam int unsigned DELAY_LO = 0;
  // Response field codes
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAYED = 2'h1;
  localparam logic [1:0] RESP_IMMEDIATE = 2'h2;
  localparam logic [1:0] RESP_BAD = 2'h3;
  // Retry field codes
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // Recognised whole-byte settings
  localparam logic [7:0] ACT_PULLDOWN = 8'h00;
  localparam logic [7:0] ACT_LATCH = 8'h80;
  localparam logic [7:0] ACT_RETRY = 8'hB8;
  // Value after reset of the action byte
  localparam logic [7:0] ACT_RESET = 8'hB8;
  // Value after reset of the retry interval in 10 us ticks
  localparam logic [23:0] RETRY_INT_RESET = 24'h0088B8;
  // Fault response states
  typedef enum logic [2:0] {
    OOVFR_IDLE,
    OOVFR_PERSIST,
    OOVFR_OFF_LATCHED,
    OOVFR_OFF_WAIT,
    OOVFR_RESTART
  } oovfr_state_t;
endpackage

// ==== verif/oovfr_monitor.sv ====
/* Port checker for the overvoltage response core.
   Assumes one clock domain and an active-low reset. */
`timescale 1ns/1ps
module oovfr_monitor (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic OV_COMPARE_I,
  input wire logic CHANNEL_ENABLE_I,
  input wire logic OUTPUT_DECAYED_I,
  input wire logic ACTION_WRITE_I,
  input wire logic [7:0] ACTION_WDATA_I,
  input wire logic CLEAR_FAULTS_I,
  input wire logic RESET_CMD_I,
  input wire logic ALERT_MASK_I,
  input wire logic [7:0] ACTION_RDATA_O,
  input wire logic COMM_FAULT_O,
  input wire logic OVERVOLTAGE_LOW_SIDE_CLAMP_O,
  input wire logic OUTPUT_DISABLE_O,
  input wire logic RETRY_START_O,
  input wire logic OUTPUT_OVERVOLTAGE_FLAG_O,
  input wire logic ALERT_N_O
);
  logic ok; // Written byte is a recognised setting
  assign ok = (ACTION_WDATA_I inside {8'h00, 8'h80, 8'hB8}) || (ACTION_WDATA_I[7:3] inside {5'h08, 5'h0F});
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  property p_flag; OV_COMPARE_I [*3] |-> ##[0:2] OUTPUT_OVERVOLTAGE_FLAG_O; endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_alert; OUTPUT_OVERVOLTAGE_FLAG_O && !ALERT_MASK_I |-> !ALERT_N_O; endproperty
  a_alert: assert property (p_alert) else $error("alert missing");
  property p_clamp; OV_COMPARE_I [*4] |-> OVERVOLTAGE_LOW_SIDE_CLAMP_O; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp missing");
  property p_write; ACTION_WRITE_I && ok |=> ACTION_RDATA_O == $past(ACTION_WDATA_I); endproperty
  a_write: assert property (p_write) else $error("byte not stored");
  property p_refuse; ACTION_WRITE_I && !ok |=> COMM_FAULT_O && $stable(ACTION_RDATA_O); endproperty
  a_refuse: assert property (p_refuse) else $error("bad byte taken");
  property p_pulse; RETRY_START_O |-> $past(OUTPUT_DECAYED_I) ##1 !RETRY_START_O; endproperty
  a_pulse: assert property (p_pulse) else $error("bad retry pulse");
  property p_noretry; ACTION_RDATA_O[5:3] == 3'h0 |-> !RETRY_START_O; endproperty
  a_noretry: assert property (p_noretry) else $error("retry without retry code");
  property p_hold; CHANNEL_ENABLE_I [*8] ##0 (OUTPUT_OVERVOLTAGE_FLAG_O && !CLEAR_FAULTS_I && !RESET_CMD_I) |=>
    OUTPUT_OVERVOLTAGE_FLAG_O;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_now; (OV_COMPARE_I && CHANNEL_ENABLE_I && ACTION_RDATA_O[7:6] == 2'h2) [*3] |-> ##[0:3] OUTPUT_DISABLE_O;
  endproperty
  a_now: assert property (p_now) else $error("late shutdown");
endmodule // oovfr_monitor
bind oovfr_core oovfr_monitor i_mon (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .OV_COMPARE_I(OV_COMPARE_I),
  .CHANNEL_ENABLE_I(CHANNEL_ENABLE_I), .OUTPUT_DECAYED_I(OUTPUT_DECAYED_I), .ACTION_WRITE_I(ACTION_WRITE_I),
  .ACTION_WDATA_I(ACTION_WDATA_I), .CLEAR_FAULTS_I(CLEAR_FAULTS_I), .RESET_CMD_I(RESET_CMD_I),
  .ALERT_MASK_I(ALERT_MASK_I),
  .ACTION_RDATA_O(ACTION_RDATA_O), .COMM_FAULT_O(COMM_FAULT_O), .OUTPUT_DISABLE_O(OUTPUT_DISABLE_O),
  .OVERVOLTAGE_LOW_SIDE_CLAMP_O(OVERVOLTAGE_LOW_SIDE_CLAMP_O), .RETRY_START_O(RETRY_START_O),
  .OUTPUT_OVERVOLTAGE_FLAG_O(OUTPUT_OVERVOLTAGE_FLAG_O), .ALERT_N_O(ALERT_N_O));

// ==== verif/oovfr_plant.sv ====
/* Far-side model: overvoltage comparator and output rail decay.
   Assumes the bench requests the pin level and the core drives disable. */
`timescale 1ns/1ps
module oovfr_plant #(
  parameter int DECAY = 40
) (
  input wire logic clk_i,
  input wire logic ov_req_i,
  input wire logic disable_i,
  output logic ov_o,
  output logic decayed_o
);
  int n = 0; // Cycles since the output went off
  // Rail drops below 12.5 percent only some time after switch-off
  always @(posedge clk_i) n <= disable_i ? n + 1 : 0;
  assign decayed_o = (n >= DECAY);
  // Comparator follows the rail level asked for by the bench
  assign ov_o = ov_req_i;
endmodule // oovfr_plant

// ==== verif/tb.sv ====
/* Self-checking bench of the overvoltage response core.
   Assumes the core, its package, the plant model and the checker. */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; $display("Error at %0t got %h exp %h", $time, a, e); end end
module tb;
  import oovfr_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, ovr = 1'b0, en = 1'b1, wr = 1'b0, clr = 1'b0, msk = 1'b0; // Stimulus
  logic [7:0] wd = 8'h00; // Write data
  logic rcmd = 1'b0, oth = 1'b0; // Reset command, other fault stop
  logic ov, dec, cf, clp, hso, dis, rs, sf, wf, of, al_n; // Observed
  logic [7:0] rd; // Stored byte
  int fails = 0, num_checks = 0, k;
  // Write, byte read back, fault expected
  logic [7:0] rows [8][3] = '{'{8'h00, 8'h00, 8'h00}, '{8'hC0, 8'h00, 8'h01}, '{8'h47, 8'h47, 8'h00},
    '{8'h3F, 8'h47, 8'h01}, '{8'h7F, 8'h7F, 8'h00}, '{8'h80, 8'h80, 8'h00}, '{8'h48, 8'h80, 8'h01},
    '{8'hB8, 8'hB8, 8'h00}};
  always #25 clk = ~clk;
  oovfr_plant i_plant (.clk_i(clk), .ov_req_i(ovr), .disable_i(dis), .ov_o(ov), .decayed_o(dec));
  oovfr_core i_dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .OV_COMPARE_I(ov), .CHANNEL_ENABLE_I(en),
    .OUTPUT_DECAYED_I(dec), .OTHER_FAULT_STOP_I(oth), .ACTION_WRITE_I(wr), .ACTION_WDATA_I(wd),
    .CLEAR_FAULTS_I(clr), .RESET_CMD_I(rcmd), .ALERT_MASK_I(msk), .RETRY_INTERVAL_SETTING_I(24'h000002),
    .ACTION_RDATA_O(rd), .COMM_FAULT_O(cf), .OVERVOLTAGE_LOW_SIDE_CLAMP_O(clp), .HIGH_SIDE_OFF_O(hso),
    .OUTPUT_DISABLE_O(dis), .RETRY_START_O(rs), .SUMMARY_OV_FLAG_O(sf), .WORD_VOUT_FLAG_O(wf),
    .OUTPUT_OVERVOLTAGE_FLAG_O(of), .ALERT_N_O(al_n));
  task automatic tick(input int n); repeat (n) @(negedge clk); endtask
  // Write then wait for the stored byte
  task automatic put(input logic [7:0] d); wd = d; wr = 1'b1; tick(1); wr = 1'b0; tick(1); endtask
  task automatic wipe(); clr = 1'b1; tick(1); clr = 1'b0; tick(1); endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog, far beyond the expected 4060 cycles
  initial begin #(20000 * 50); fails++; conclude(); end
  initial begin
    tick(10); rstn = 1'b1;
    `CHK(rd, ACT_RESET)
    `CHK(al_n, 1'b1)
    for (k = 0; k < 8; k++) begin
      put(rows[k][0]);
      `CHK(rd, rows[k][1])
      `CHK(cf, rows[k][2][0])
      wipe();
    end
    // Pull-down only: clamp follows the fault, output stays on
    put(ACT_PULLDOWN); ovr = 1'b1; tick(10);
    `CHK({clp, hso, dis}, 3'h6)
    `CHK({sf, wf, of, al_n}, 4'hE)
    ovr = 1'b0; tick(6);
    `CHK({clp, of}, 2'h1)
    msk = 1'b1; tick(1);
    `CHK(al_n, 1'b1)
    msk = 1'b0; wipe();
    `CHK(of, 1'b0)
    // Two-tick persistence: short glitch restarts the count, long one latches off
    put(8'h42); ovr = 1'b1; tick(150); ovr = 1'b0; tick(5);
    `CHK(dis, 1'b0)
    ovr = 1'b1; tick(500);
    `CHK(dis, 1'b1)
    ovr = 1'b0; tick(1000);
    `CHK(dis, 1'b1)
    en = 1'b0; tick(10); en = 1'b1; tick(10);
    `CHK({dis, of}, 2'h0)
    // Immediate shutdown with endless retry after the interval
    put(ACT_RETRY); ovr = 1'b1; tick(8);
    `CHK(dis, 1'b1)
    ovr = 1'b0;
    for (k = 0; k < 3000 && rs !== 1'b1; k++) tick(1);
    `CHK(rs, 1'b1)
    `CHK(k >= TICK_CYC - 8, 1'b1)
    tick(2);
    `CHK(dis, 1'b0)
    // Latch-off code: no retry, reset command releases it
    put(ACT_LATCH);
    ovr = 1'b1;
    tick(8);
    `CHK(dis, 1'b1)
    ovr = 1'b0;
    for (k = 0; k < 600 && rs !== 1'b1; k++) tick(1);
    `CHK({rs, dis}, 2'h1)
    rcmd = 1'b1;
    tick(1);
    rcmd = 1'b0;
    tick(1);
    `CHK({dis, of}, 2'h0)
    // Delayed code 78+2: shuts down after two ticks, then retries
    put(8'h7A);
    ovr = 1'b1;
    for (k = 0; k < 600 && dis !== 1'b1; k++) tick(1);
    `CHK(k >= TICK_CYC && k <= 2 * TICK_CYC + 8, 1'b1)
    ovr = 1'b0;
    for (k = 0; k < 1000 && rs !== 1'b1; k++) tick(1);
    `CHK(rs, 1'b1)
    // Another fault during the retry wait stops the retries
    put(ACT_RETRY);
    ovr = 1'b1;
    tick(8);
    oth = 1'b1;
    tick(1);
    oth = 1'b0;
    ovr = 1'b0;
    for (k = 0; k < 600 && rs !== 1'b1; k++) tick(1);
    `CHK({rs, dis}, 2'h1)
    en = 1'b0;
    tick(10);
    en = 1'b1;
    tick(10);
    `CHK({dis, of}, 2'h0)
    // Reset in mid-run: setting, flags and fault go back to reset values
    put(8'h40);
    put(8'hC0);
    ovr = 1'b1;
    tick(8);
    rstn = 1'b0;
    ovr = 1'b0;
    tick(2);
    `CHK({rd, cf, of, dis, al_n}, {ACT_RESET, 4'h1})
    rstn = 1'b1;
    put(8'h47);
    `CHK(rd, 8'h47)
    conclude();
  end
endmodule // tb
